// ===== ext_mem_pkg.sv
package ext_mem_pkg;
  // special-function addresses
  localparam logic [7:0] EXT_CTRL_ADDR = 8'hA2;
  localparam logic [7:0] PAGE_ADDR = 8'hA1;
  // reset values
  localparam logic [7:0] EXT_CTRL_RST = 8'h70;
  localparam logic [7:0] PAGE_RST = 8'h00;
  // control register fields
  localparam int ROLE_BIT = 7;
  localparam int BANK_MSB = 3;
  localparam int BANK_LSB = 0;
  localparam logic [7:0] RSVD_ONES = 8'h70;
  // high address bits that pick a chip select
  localparam int CS_MSB = 7;
  localparam int CS_LSB = 6;
  // bus cycle kinds presented by the core
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_CODE_RD = 2'h1;
  localparam logic [1:0] KIND_XDATA_PTR = 2'h2;
  localparam logic [1:0] KIND_XDATA_PAGE = 2'h3;
  // strobe timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus cycle sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STRB = 3'b010,
    ST_DONE = 3'b100
  } bus_state_e;
endpackage

// ===== addr_ext_mux.sv
`timescale 1ns/1ps
`default_nettype none
// picks the value of the 4-bit extension port
module addr_ext_mux
  import ext_mem_pkg::*;
(
  // control
  input wire logic cs_mode_in,
  input wire logic data_acc_in,
  input wire logic [3:0] bank_in,
  // address in the bus cycle
  input wire logic [1:0] high_bits_in,
  // port value
  output logic [3:0] port_out
);
  // one active-low select per 16K region
  wire [3:0] sel_n;
  // bank only while a data-type access runs, zero otherwise
  wire [3:0] ext_addr;

  assign sel_n = ~(4'h1 << high_bits_in);
  assign ext_addr = data_acc_in ? bank_in : 4'h0;
  assign port_out = cs_mode_in ? sel_n : ext_addr;
endmodule
`default_nettype wire

// ===== ext_mem_addr_extension.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_addr_extension
  import ext_mem_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_CYC
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // special-function register access from the core
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic sfr_bit_op_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // bus cycle requests from the core
  input wire logic cyc_valid_in,
  input wire logic [1:0] cyc_kind_in,
  input wire logic cyc_write_in,
  input wire logic [15:0] cyc_addr_in,
  input wire logic [7:0] cyc_wdata_in,
  output logic cyc_busy_out,
  output logic cyc_done_out,
  output logic [7:0] cyc_rdata_out,
  // external memory pins
  input wire logic [7:0] ext_data_port_in,
  output logic [7:0] ext_data_port_out,
  output logic ext_data_port_oe_out,
  output logic [7:0] low_addr_port_out,
  output logic [7:0] high_addr_port_out,
  output logic [3:0] addr_ext_port_out,
  output logic program_store_strobe_n_out,
  output logic ram_wr_strobe_n_out,
  output logic ram_rd_strobe_n_out
);
  // registers
  logic [7:0] ctrl_ff; // extended_address_control
  logic [7:0] page_ff; // high_byte_page
  bus_state_e st_ff;
  bus_state_e nxt_st;
  logic [3:0] cnt_ff; // strobe cycles left
  logic [3:0] nxt_cnt;
  logic data_acc_ff; // current cycle is code read or xdata
  logic nxt_data_acc;
  logic [7:0] nxt_low;
  logic [7:0] nxt_high;
  logic [3:0] nxt_ext;
  logic nxt_program_store_strobe_n;
  logic nxt_wr_n;
  logic nxt_rd_n;
  logic wr_cyc_ff; // current cycle is a ram write
  logic nxt_wr_cyc;
  // data pins come from outside: two-stage synchroniser
  logic [7:0] din_meta_ff;
  logic [7:0] din_sync_ff;

  // register decode; single-bit instructions are not answered
  wire ctrl_sel = (sfr_addr_in == EXT_CTRL_ADDR) && !sfr_bit_op_in;
  wire page_sel = (sfr_addr_in == PAGE_ADDR) && !sfr_bit_op_in;
  wire ctrl_wr = sfr_wr_in && ctrl_sel;
  wire page_wr = sfr_wr_in && page_sel;
  // reserved bits forced to ones on every store
  wire [7:0] ctrl_wval = sfr_wdata_in | RSVD_ONES;
  // forward a same-cycle write so the access sees the new bank
  wire [7:0] ctrl_eff = ctrl_wr ? ctrl_wval : ctrl_ff;
  wire [7:0] page_eff = page_wr ? sfr_wdata_in : page_ff;
  wire start = (st_ff == ST_IDLE) && cyc_valid_in;
  wire is_fetch = (cyc_kind_in == KIND_FETCH);
  wire is_code = (cyc_kind_in == KIND_FETCH) || (cyc_kind_in == KIND_CODE_RD);
  wire strobe_end = (st_ff == ST_STRB) && (cnt_ff == 4'h0);
  wire [7:0] rd_mux = ctrl_sel ? (ctrl_ff | RSVD_ONES) : page_ff;

  // control and page registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_ff <= EXT_CTRL_RST;
      page_ff <= PAGE_RST;
    end else begin
      ctrl_ff <= ctrl_eff;
      page_ff <= page_eff;
    end
  end

  // register read port, answered one cycle after the request
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
    end else begin
      sfr_hit_out <= sfr_rd_in && (ctrl_sel || page_sel);
      sfr_rdata_out <= (sfr_rd_in && (ctrl_sel || page_sel)) ? rd_mux : 8'h00;
    end
  end

  // bus cycle sequencer next state
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_IDLE: begin
        if (cyc_valid_in) begin
          nxt_st = ST_STRB;
          nxt_cnt = 4'(STROBE_CYCLES - 1);
        end
      end
      ST_STRB: begin
        if (cnt_ff == 4'h0) begin
          nxt_st = ST_DONE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_DONE: begin
        nxt_st = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
        nxt_cnt = 4'h0;
      end
    endcase
  end

  // address and strobe next values
  always_comb begin
    nxt_low = low_addr_port_out;
    nxt_high = high_addr_port_out;
    nxt_data_acc = data_acc_ff;
    nxt_wr_cyc = wr_cyc_ff;
    nxt_program_store_strobe_n = program_store_strobe_n_out;
    nxt_wr_n = ram_wr_strobe_n_out;
    nxt_rd_n = ram_rd_strobe_n_out;
    if (start) begin
      nxt_low = cyc_addr_in[7:0];
      // paged xdata uses the page register as high byte
      nxt_high = (cyc_kind_in == KIND_XDATA_PAGE) ? page_eff : cyc_addr_in[15:8];
      nxt_data_acc = !is_fetch;
      nxt_wr_cyc = !is_code && cyc_write_in;
      nxt_program_store_strobe_n = !is_code;
      nxt_wr_n = !(!is_code && cyc_write_in);
      nxt_rd_n = !(!is_code && !cyc_write_in);
    end else if (strobe_end) begin
      nxt_program_store_strobe_n = 1'b1;
      nxt_wr_n = 1'b1;
      nxt_rd_n = 1'b1;
    end else if (st_ff == ST_DONE) begin
      // address stays put, extension drops back to zero in bank mode; select mode keeps the select
      nxt_data_acc = 1'b0;
      nxt_wr_cyc = 1'b0;
    end
  end

  // extension port value from the next-cycle address
  addr_ext_mux u_ext_mux (
    .cs_mode_in(ctrl_eff[ROLE_BIT]),
    .data_acc_in(nxt_data_acc),
    .bank_in(ctrl_eff[BANK_MSB:BANK_LSB]),
    .high_bits_in(nxt_high[CS_MSB:CS_LSB]),
    .port_out(nxt_ext)
  );

  // sequencer state
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // pin drivers: every pin comes straight from a flop
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      low_addr_port_out <= 8'h00;
      high_addr_port_out <= 8'h00;
      addr_ext_port_out <= 4'h0;
      data_acc_ff <= 1'b0;
      wr_cyc_ff <= 1'b0;
      program_store_strobe_n_out <= 1'b1;
      ram_wr_strobe_n_out <= 1'b1;
      ram_rd_strobe_n_out <= 1'b1;
    end else begin
      low_addr_port_out <= nxt_low;
      high_addr_port_out <= nxt_high;
      addr_ext_port_out <= nxt_ext;
      data_acc_ff <= nxt_data_acc;
      wr_cyc_ff <= nxt_wr_cyc;
      program_store_strobe_n_out <= nxt_program_store_strobe_n;
      ram_wr_strobe_n_out <= nxt_wr_n;
      ram_rd_strobe_n_out <= nxt_rd_n;
    end
  end

  // write data held on the data port for the whole write cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ext_data_port_out <= 8'h00;
      ext_data_port_oe_out <= 1'b0;
    end else begin
      if (start) begin
        ext_data_port_out <= cyc_wdata_in;
      end
      ext_data_port_oe_out <= nxt_wr_cyc;
    end
  end

  // input synchroniser; stage one is read only by stage two
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      din_meta_ff <= 8'h00;
      din_sync_ff <= 8'h00;
    end else begin
      din_meta_ff <= ext_data_port_in;
      din_sync_ff <= din_meta_ff;
    end
  end

  // read data caught on the last strobe cycle; lags the pins by two
  // cycles, so the strobe must stay at least three cycles long
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cyc_rdata_out <= 8'h00;
      cyc_done_out <= 1'b0;
      cyc_busy_out <= 1'b0;
    end else begin
      if (strobe_end && !wr_cyc_ff) begin
        cyc_rdata_out <= din_sync_ff;
      end
      cyc_done_out <= strobe_end;
      cyc_busy_out <= (nxt_st != ST_IDLE);
    end
  end

  // checks
  sequence fetch_start_s;
    start && is_code;
  endsequence
  sequence strobe_pulse_s;
    ##1 !program_store_strobe_n_out [*4] ##1 program_store_strobe_n_out;
  endsequence

  rom_strobe_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    fetch_start_s |-> strobe_pulse_s)
    else $error("rom strobe width wrong");

  addr_drive_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (start && cyc_kind_in != KIND_XDATA_PAGE) |=>
      low_addr_port_out == $past(cyc_addr_in[7:0]) && high_addr_port_out == $past(cyc_addr_in[15:8]))
    else $error("address ports not driven");

  page_high_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (start && cyc_kind_in == KIND_XDATA_PAGE) |=> high_addr_port_out == $past(page_eff))
    else $error("page byte not on high port");

  fetch_zero_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (start && is_fetch && !ctrl_eff[ROLE_BIT]) |=> (addr_ext_port_out == 4'h0) [*4])
    else $error("fetch drove upper bits");

  bank_drive_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (start && !is_fetch && !ctrl_eff[ROLE_BIT]) |=>
      addr_ext_port_out == ($past(ctrl_wr) ? $past(sfr_wdata_in[3:0]) : $past(ctrl_ff[3:0])))
    else $error("bank not driven");

  bank_fwd_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (start && !is_fetch && ctrl_wr && !sfr_wdata_in[ROLE_BIT]) |=> addr_ext_port_out == $past(sfr_wdata_in[3:0]))
    else $error("new bank not used");

  idle_zero_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (st_ff == ST_IDLE && !ctrl_ff[ROLE_BIT]) |-> addr_ext_port_out == 4'h0)
    else $error("extension not zero when idle");

  one_select_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    ctrl_ff[ROLE_BIT] |-> $onehot(~addr_ext_port_out))
    else $error("select count wrong");

  select_region_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    ctrl_ff[ROLE_BIT] |-> addr_ext_port_out == ~(4'h1 << high_addr_port_out[7:6]))
    else $error("wrong select for region");

  select_stable_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (ctrl_ff[ROLE_BIT] && $stable(ctrl_ff[ROLE_BIT]) && $stable(high_addr_port_out))
      |-> $stable(addr_ext_port_out))
    else $error("select moved without address");

  bit_op_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (sfr_wr_in && sfr_bit_op_in) |=> ctrl_ff == $past(ctrl_ff))
    else $error("bit op changed control");

  rsvd_ones_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (sfr_rd_in && ctrl_sel) |=> sfr_hit_out && sfr_rdata_out[6:4] == 3'b111)
    else $error("reserved bits not ones");

  reset_val_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    $past(srst_in) |-> ctrl_ff == EXT_CTRL_RST)
    else $error("control reset value wrong");
endmodule
`default_nettype wire

// ===== ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// external rom and one-byte ram standing on the memory pins
module ext_mem_model (
  // address and strobes from the device
  input wire logic [7:0] low_in,
  input wire logic [7:0] high_in,
  input wire logic [3:0] ext_in,
  input wire logic program_store_strobe_n_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  // data pins
  input wire logic [7:0] wdata_in,
  input wire logic oe_in,
  output logic [7:0] data_out
);
  logic [19:0] ram_addr_q = 20'hFFFFF; // last written location
  logic [7:0] ram_data_q = 8'h00; // last written byte
  logic [7:0] rd_val; // value offered on a read
  logic [7:0] last_q = 8'h00; // last value driven
  logic sel; // any read strobe low
  // capture at the end of the write strobe
  always @(posedge wr_n_in) begin
    if (oe_in === 1'b1) begin
      ram_addr_q = {ext_in, high_in, low_in};
      ram_data_q = wdata_in;
    end
  end
  // rom pattern unless a ram read (rd_n low) hits the ram byte
  assign rd_val = (!rd_n_in && ram_addr_q == {ext_in, high_in, low_in}) ? ram_data_q :
    (low_in ^ high_in ^ {ext_in, ext_in} ^ 8'h5A);
  assign sel = !program_store_strobe_n_in || !rd_n_in;
  // remember what was driven so release can show its inverse
  always @* begin
    if (sel) begin
      last_q = rd_val;
    end
  end
  // released pins never keep the old value, to catch late sampling
  assign data_out = sel ? rd_val : ~last_q;
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ext_mem_pkg::*;
  logic mclk_in = 0;
  logic srst_in = 1;
  logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
  logic sfr_wr_in = 0, sfr_rd_in = 0, sfr_bit_op_in = 0, sfr_hit_out;
  logic cyc_valid_in = 0, cyc_write_in = 0, cyc_busy_out, cyc_done_out;
  logic [1:0] cyc_kind_in = 2'h0;
  logic [15:0] cyc_addr_in = 16'h0000;
  logic [7:0] cyc_wdata_in = 8'h00, cyc_rdata_out, pins, dout, low, high;
  logic oe, program_store_strobe_n, wr_n, rd_n;
  logic [3:0] ext;
  int n_fail = 0;
  int samples_checked = 0;
  // clock at 100 MHz
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  ext_mem_addr_extension dut (.mclk_in(mclk_in), .srst_in(srst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_bit_op_in(sfr_bit_op_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
    .cyc_valid_in(cyc_valid_in), .cyc_kind_in(cyc_kind_in), .cyc_write_in(cyc_write_in),
    .cyc_addr_in(cyc_addr_in), .cyc_wdata_in(cyc_wdata_in), .cyc_busy_out(cyc_busy_out),
    .cyc_done_out(cyc_done_out), .cyc_rdata_out(cyc_rdata_out), .ext_data_port_in(pins),
    .ext_data_port_out(dout), .ext_data_port_oe_out(oe), .low_addr_port_out(low),
    .high_addr_port_out(high), .addr_ext_port_out(ext), .program_store_strobe_n_out(program_store_strobe_n),
    .ram_wr_strobe_n_out(wr_n), .ram_rd_strobe_n_out(rd_n));
  ext_mem_model mem (.low_in(low), .high_in(high), .ext_in(ext), .program_store_strobe_n_in(program_store_strobe_n), .wr_n_in(wr_n),
    .rd_n_in(rd_n), .wdata_in(dout), .oe_in(oe), .data_out(pins));
  // verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one comparison of any port value
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // register write, bit op flag as given
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d, input logic bit_op);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_bit_op_in = bit_op;
    sfr_wr_in = 1;
    @(posedge mclk_in);
    #1 sfr_wr_in = 0;
    sfr_bit_op_in = 0;
    // one quiet edge, so a following access never re-raises a strobe in this step
    @(posedge mclk_in);
    #1;
  endtask
  // register read, answer checked just after the taking edge
  task automatic sfr_rd(input logic [7:0] a, input logic hit, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_rd_in = 1;
    @(posedge mclk_in);
    #1 sfr_rd_in = 0;
    chk("hit", {15'h0, hit}, {15'h0, sfr_hit_out});
    chk("sfr_rdata", {8'h0, d}, {8'h0, sfr_rdata_out});
    // the answer stands for one cycle only
    @(posedge mclk_in);
    #1 chk("hit_end", 16'h0, {15'h0, sfr_hit_out});
    chk("sfr_rdata_end", 16'h0, {8'h0, sfr_rdata_out});
  endtask
  // expected rom byte, same pattern the memory model offers
  function automatic logic [7:0] rom(input logic [3:0] e, input logic [7:0] h, input logic [7:0] l);
    return l ^ h ^ {e, e} ^ 8'h5A;
  endfunction
  // one bus cycle: ports during the strobe, read data, idle extension value
  task automatic cyc(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] wd,
      input logic [3:0] x_ext, input logic [7:0] x_high, input logic [2:0] x_strb,
      input logic [7:0] x_rd, input logic [3:0] x_idle);
    int n;
    n = 0;
    // requests while busy are dropped, so wait for idle
    while (cyc_busy_out !== 1'b0 && n < 20) begin
      @(posedge mclk_in);
      #1 n++;
    end
    // a wait that runs out counts as a mismatch here
    chk("idle_wait", 16'h0, {15'h0, cyc_busy_out});
    cyc_kind_in = k;
    cyc_write_in = w;
    cyc_addr_in = a;
    cyc_wdata_in = wd;
    cyc_valid_in = 1;
    @(posedge mclk_in);
    #1 cyc_valid_in = 0;
    // a control write raised along with the request lasts one edge
    sfr_wr_in = 0;
    @(posedge mclk_in);
    #1 chk("busy", 16'h1, {15'h0, cyc_busy_out});
    chk("low", {8'h0, a[7:0]}, {8'h0, low});
    chk("high", {8'h0, x_high}, {8'h0, high});
    chk("ext", {12'h0, x_ext}, {12'h0, ext});
    chk("strobes", {13'h0, x_strb}, {13'h0, program_store_strobe_n, wr_n, rd_n});
    chk("oe", {15'h0, w}, {15'h0, oe});
    if (w) begin
      chk("wdata", {8'h0, wd}, {8'h0, dout});
    end
    n = 0;
    // done is a one-cycle pulse, watched every cycle
    while (cyc_done_out !== 1'b1 && n < 10) begin
      @(posedge mclk_in);
      #1 n++;
    end
    chk("done", 16'h1, {15'h0, cyc_done_out});
    if (!w) begin
      chk("rdata", {8'h0, x_rd}, {8'h0, cyc_rdata_out});
    end
    @(posedge mclk_in);
    #1 chk("ext_idle", {12'h0, x_idle}, {12'h0, ext});
    chk("strobes_idle", 16'h7, {13'h0, program_store_strobe_n, wr_n, rd_n});
  endtask
  // hang guard, far beyond the expected run time
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    #1 srst_in = 0;
    sfr_rd(EXT_CTRL_ADDR, 1, 8'h70);
    sfr_rd(PAGE_ADDR, 1, 8'h00);
    sfr_rd(8'h55, 0, 8'h00);
    sfr_wr(EXT_CTRL_ADDR, 8'h02, 0);
    sfr_rd(EXT_CTRL_ADDR, 1, 8'h72);
    sfr_wr(EXT_CTRL_ADDR, 8'h85, 1);
    sfr_rd(EXT_CTRL_ADDR, 1, 8'h72);
    // fetch keeps the upper bits at zero, code read shows the bank
    cyc(KIND_FETCH, 0, 16'h1234, 8'h00, 4'h0, 8'h12, 3'b011, rom(4'h0, 8'h12, 8'h34), 4'h0);
    cyc(KIND_CODE_RD, 0, 16'hABCD, 8'h00, 4'h2, 8'hAB, 3'b011, rom(4'h2, 8'hAB, 8'hCD), 4'h0);
    // new bank used by the next external data write and read-back
    sfr_wr(EXT_CTRL_ADDR, 8'h03, 0);
    cyc(KIND_XDATA_PTR, 1, 16'hFF40, 8'h3C, 4'h3, 8'hFF, 3'b101, 8'h00, 4'h0);
    cyc(KIND_XDATA_PTR, 0, 16'hFF40, 8'h00, 4'h3, 8'hFF, 3'b110, 8'h3C, 4'h0);
    // paged access puts the page register on the high port
    sfr_wr(PAGE_ADDR, 8'hFF, 0);
    cyc(KIND_XDATA_PAGE, 0, 16'h0040, 8'h00, 4'h3, 8'hFF, 3'b110, 8'h3C, 4'h0);
    // control write in the very request cycle: that access already uses bank 5
    sfr_addr_in = EXT_CTRL_ADDR;
    sfr_wdata_in = 8'h05;
    sfr_wr_in = 1;
    cyc(KIND_CODE_RD, 0, 16'h2000, 8'h00, 4'h5, 8'h20, 3'b011, rom(4'h5, 8'h20, 8'h00), 4'h0);
    // select mode: one low select per 16K region, fetches included
    sfr_wr(EXT_CTRL_ADDR, 8'h80, 0);
    for (int i = 0; i < 4; i++) begin
      cyc(KIND_FETCH, 0, {i[1:0], 14'h0510}, 8'h00, ~(4'h1 << i), {i[1:0], 6'h05}, 3'b011,
        rom(~(4'h1 << i), {i[1:0], 6'h05}, 8'h10), ~(4'h1 << i));
    end
    // a second reset brings the control register and extension port back
    srst_in = 1;
    repeat (2) @(posedge mclk_in);
    #1 srst_in = 0;
    chk("ext_reset", 16'h0, {12'h0, ext});
    sfr_rd(EXT_CTRL_ADDR, 1, 8'h70);
    sfr_rd(PAGE_ADDR, 1, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
